/* File: rtl/tpo_ctrl.sv */
// Design decision made here: the address-and-strobe port.
`timescale 1ns/10ps
module tpo_ctrl
(
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  // register port
  input wire logic [15:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  // frame timing from the transmit framer
  input wire logic frame_start_in,
  // j1 sources
  input wire logic [7:0] trace_byte_in,
  input wire logic path_overhead_serial_in,
  // outbound overhead
  output tpo_pkg::tpo_ptr_t ptr_out,
  output tpo_pkg::tpo_poh_t poh_out,
  output logic [1:0] j1_method_out,
  output logic [9:0] spe_offset_out
);
  logic [7:0] z5_value;
  logic [7:0] ctrl;
  logic [7:0] j1ctl;
  logic [7:0] j1_value;
  logic [7:0] pohctl;
  logic [7:0] arb_h1;
  logic [7:0] arb_h2;
  logic [9:0] ptr;
  logic neg_pend;
  logic pos_pend;
  logic one_pend;
  logic force_q;
  logic force_rise;
  logic ser_s1;
  logic ser_s2;
  logic [7:0] ser_shift;
  logic [7:0] ser_byte;
  logic [2:0] ser_cnt;
  logic quiet;
  logic allow;
  logic adjust;
  logic [9:0] ptr_dec_word;
  logic [9:0] ptr_inc_word;
  tpo_pkg::tpo_ev_t next_ev;
  logic [9:0] arb_ptr;

  function automatic logic wr_hit(input logic [15:0] a, input logic [15:0] ofs);
    wr_hit = (a == ofs);
  endfunction : wr_hit

  function automatic logic [7:0] h1_byte(input logic [3:0] n, input logic [1:0] ss,
                                         input logic [9:0] p);
    h1_byte = {n, ss, p[9:8]};
  endfunction : h1_byte

  // invert bits 9,7,5,3,1 (i) or 8,6,4,2,0 (d)
  function automatic logic [9:0] flip(input logic [9:0] p, input logic odd);
    flip = odd ? (p ^ 10'h2aa) : (p ^ 10'h155);
  endfunction : flip

  assign arb_ptr = {arb_h1[1:0], arb_h2};
  assign ptr_dec_word = flip(ptr, 1'b0);
  assign ptr_inc_word = flip(ptr, 1'b1);

  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      z5_value <= tpo_pkg::RST_BYTE;
      j1ctl <= tpo_pkg::RST_BYTE;
      j1_value <= tpo_pkg::RST_BYTE;
      pohctl <= tpo_pkg::RST_BYTE;
      arb_h1 <= tpo_pkg::RST_BYTE;
      arb_h2 <= tpo_pkg::RST_BYTE;
    end
    else if (ce_in && wr_in)
    begin
      if (wr_hit(addr_in, tpo_pkg::OFS_Z5))
        z5_value <= wdata_in;
      if (wr_hit(addr_in, tpo_pkg::OFS_J1CTL))
        j1ctl <= wdata_in & tpo_pkg::J1CTL_MASK;
      if (wr_hit(addr_in, tpo_pkg::OFS_J1VAL))
        j1_value <= wdata_in;
      if (wr_hit(addr_in, tpo_pkg::OFS_POHCTL))
        pohctl <= wdata_in & tpo_pkg::POHCTL_MASK;
      if (wr_hit(addr_in, tpo_pkg::OFS_ARB_H1))
        arb_h1 <= wdata_in;
      if (wr_hit(addr_in, tpo_pkg::OFS_ARB_H2))
        arb_h2 <= wdata_in;
    end
  end

  // control register; one-shot bits are pending until the frame takes them
  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      ctrl <= tpo_pkg::RST_BYTE;
      neg_pend <= 1'b0;
      pos_pend <= 1'b0;
      one_pend <= 1'b0;
    end
    else if (ce_in)
    begin
      if (frame_start_in)
      begin
        if (next_ev == tpo_pkg::TPO_EV_NEG)
          neg_pend <= 1'b0;
        if (next_ev == tpo_pkg::TPO_EV_POS)
          pos_pend <= 1'b0;
        if (next_ev == tpo_pkg::TPO_EV_NDF)
          one_pend <= 1'b0;
      end
      if (wr_in && wr_hit(addr_in, tpo_pkg::OFS_CTRL))
      begin
        ctrl <= wdata_in & tpo_pkg::CTRL_MASK & 8'h32;
        if (wdata_in[tpo_pkg::B_NEG])
          neg_pend <= 1'b1;
        if (wdata_in[tpo_pkg::B_POS])
          pos_pend <= 1'b1;
        if (wdata_in[tpo_pkg::B_ONE])
          one_pend <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
      force_q <= 1'b0;
    else if (ce_in)
      force_q <= ctrl[tpo_pkg::B_FORCE];
  end
  assign force_rise = ctrl[tpo_pkg::B_FORCE] && !force_q;

  assign allow = !ctrl[tpo_pkg::B_GUARD] || quiet;

  // event chosen for the coming frame
  always_comb
  begin
    next_ev = tpo_pkg::TPO_EV_NONE;
    if (allow && ctrl[tpo_pkg::B_CONT])
      next_ev = tpo_pkg::TPO_EV_NDF;
    else if (allow && one_pend)
      next_ev = tpo_pkg::TPO_EV_NDF;
    else if (allow && neg_pend)
      next_ev = tpo_pkg::TPO_EV_NEG;
    else if (allow && pos_pend)
      next_ev = tpo_pkg::TPO_EV_POS;
  end

  assign adjust = ce_in && frame_start_in && (next_ev != tpo_pkg::TPO_EV_NONE);

  tpo_guard u_guard
  (
    .clk_sys_in(clk_sys_in),
    .rstn_in(rstn_in),
    .ce_in(ce_in),
    .frame_in(frame_start_in),
    .adjust_in(adjust),
    .quiet_out(quiet)
  );

  // pointer and outbound h1/h2, updated at frame start; h1/h2 also on override rise
  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      ptr <= tpo_pkg::RST_PTR;
      ptr_out <= '0;
      spe_offset_out <= tpo_pkg::RST_PTR;
    end
    else if (ce_in && frame_start_in)
    begin
      ptr_out.neg_stuff <= (next_ev == tpo_pkg::TPO_EV_NEG);
      ptr_out.pos_stuff <= (next_ev == tpo_pkg::TPO_EV_POS);
      case (next_ev)
        tpo_pkg::TPO_EV_NEG:
        begin
          ptr <= ptr - 10'h001;
          spe_offset_out <= ptr - 10'h001;
          {ptr_out.h1, ptr_out.h2} <= {h1_byte(tpo_pkg::NDF_NORM, tpo_pkg::SS_BITS,
            ptr_dec_word), ptr_dec_word[7:0]};
        end
        tpo_pkg::TPO_EV_POS:
        begin
          ptr <= ptr + 10'h001;
          spe_offset_out <= ptr + 10'h001;
          {ptr_out.h1, ptr_out.h2} <= {h1_byte(tpo_pkg::NDF_NORM, tpo_pkg::SS_BITS,
            ptr_inc_word), ptr_inc_word[7:0]};
        end
        tpo_pkg::TPO_EV_NDF:
        begin
          ptr <= arb_ptr;
          spe_offset_out <= arb_ptr;
          {ptr_out.h1, ptr_out.h2} <= {h1_byte(tpo_pkg::NDF_SET, arb_h1[3:2], arb_ptr),
            arb_h2};
        end
        default:
        begin
          spe_offset_out <= ptr;
          if (ctrl[tpo_pkg::B_FORCE])
            {ptr_out.h1, ptr_out.h2} <= {arb_h1, arb_h2};
          else
            {ptr_out.h1, ptr_out.h2} <= {h1_byte(tpo_pkg::NDF_NORM, tpo_pkg::SS_BITS, ptr),
              ptr[7:0]};
        end
      endcase
    end
    else if (ce_in && force_rise)
      {ptr_out.h1, ptr_out.h2} <= {arb_h1, arb_h2};
  end

  // serial path overhead input, synchronised then shifted in
  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      ser_s1 <= 1'b0;
      ser_s2 <= 1'b0;
      ser_shift <= tpo_pkg::RST_BYTE;
      ser_byte <= tpo_pkg::RST_BYTE;
      ser_cnt <= 3'h0;
    end
    else if (ce_in)
    begin
      ser_s1 <= path_overhead_serial_in;
      ser_s2 <= ser_s1;
      ser_shift <= {ser_shift[6:0], ser_s2};
      ser_cnt <= frame_start_in ? 3'h0 : ser_cnt + 3'h1;
      if (ser_cnt == 3'h7)
        ser_byte <= {ser_shift[6:0], ser_s2};
    end
  end

  // j1, z5 and trace length
  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      poh_out <= '0;
      j1_method_out <= 2'h0;
    end
    else if (ce_in)
    begin
      j1_method_out <= j1ctl[1:0];
      case (j1ctl[1:0])
        2'h0: poh_out.j1 <= tpo_pkg::J1_ZERO;
        2'h1: poh_out.j1 <= trace_byte_in;
        2'h2: poh_out.j1 <= j1_value;
        default: poh_out.j1 <= ser_byte;
      endcase
      if (!pohctl[tpo_pkg::B_Z5SEL])
        poh_out.z5 <= z5_value;
      else
        poh_out.z5 <= ser_byte;
      case (j1ctl[3:2])
        2'h0: poh_out.trace_len <= tpo_pkg::LEN_1;
        2'h1: poh_out.trace_len <= tpo_pkg::LEN_16;
        default: poh_out.trace_len <= tpo_pkg::LEN_64;
      endcase
    end
  end

  // read data one cycle after the strobe
  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
      rdata_out <= tpo_pkg::RST_BYTE;
    else if (ce_in)
    begin
      rdata_out <= tpo_pkg::RST_BYTE;
      if (rd_in)
      begin
        case (addr_in)
          tpo_pkg::OFS_Z5: rdata_out <= z5_value;
          tpo_pkg::OFS_CTRL: rdata_out <= ctrl;
          tpo_pkg::OFS_J1CTL: rdata_out <= j1ctl;
          tpo_pkg::OFS_J1VAL: rdata_out <= j1_value;
          tpo_pkg::OFS_POHCTL: rdata_out <= pohctl;
          tpo_pkg::OFS_ARB_H1: rdata_out <= arb_h1;
          tpo_pkg::OFS_ARB_H2: rdata_out <= arb_h2;
          tpo_pkg::OFS_PTR_HI: rdata_out <= {6'h00, ptr[9:8]};
          tpo_pkg::OFS_PTR_LO: rdata_out <= ptr[7:0];
          default: rdata_out <= tpo_pkg::RST_BYTE;
        endcase
      end
    end
  end

  property p_neg_dec;
    @(posedge clk_sys_in) disable iff (!rstn_in)
    (ce_in && frame_start_in && next_ev == tpo_pkg::TPO_EV_NEG) |=> ptr == $past(ptr) - 10'h001;
  endproperty
  a_neg_dec: assert property (p_neg_dec) else $error("neg stuff did not decrement");

  property p_pos_inc;
    @(posedge clk_sys_in) disable iff (!rstn_in)
    (ce_in && frame_start_in && next_ev == tpo_pkg::TPO_EV_POS) |=> ptr == $past(ptr) + 10'h001;
  endproperty
  a_pos_inc: assert property (p_pos_inc) else $error("pos stuff did not increment");

  property p_guard;
    @(posedge clk_sys_in) disable iff (!rstn_in)
    (ctrl[tpo_pkg::B_GUARD] && !quiet) |-> next_ev == tpo_pkg::TPO_EV_NONE;
  endproperty
  a_guard: assert property (p_guard) else $error("event inside guard window");

  property p_z5;
    @(posedge clk_sys_in) disable iff (!rstn_in)
    (ce_in && !pohctl[tpo_pkg::B_Z5SEL]) |=> poh_out.z5 == $past(z5_value);
  endproperty
  a_z5: assert property (p_z5) else $error("z5 not from register");

  property p_j1_zero;
    @(posedge clk_sys_in) disable iff (!rstn_in)
    (ce_in && j1ctl[1:0] == 2'h0) |=> poh_out.j1 == tpo_pkg::J1_ZERO;
  endproperty
  a_j1_zero: assert property (p_j1_zero) else $error("j1 not zero");

  property p_len;
    @(posedge clk_sys_in) disable iff (!rstn_in)
    (ce_in && j1ctl[3]) |=> poh_out.trace_len == tpo_pkg::LEN_64;
  endproperty
  a_len: assert property (p_len) else $error("trace length wrong");

  property p_ndf_flag;
    @(posedge clk_sys_in) disable iff (!rstn_in)
    (ce_in && frame_start_in && next_ev == tpo_pkg::TPO_EV_NDF) |=>
      ptr_out.h1[7:4] == tpo_pkg::NDF_SET && ptr == $past(arb_ptr);
  endproperty
  a_ndf_flag: assert property (p_ndf_flag) else $error("new data flag wrong");

  property p_unused;
    @(posedge clk_sys_in) disable iff (!rstn_in)
    ctrl[7:6] == 2'h0 && ctrl[3:2] == 2'h0 && ctrl[0] == 1'b0 && j1ctl[7:4] == 4'h0;
  endproperty
  a_unused: assert property (p_unused) else $error("unused bits set");
endmodule : tpo_ctrl

/* File: rtl/tpo_guard.sv */
`timescale 1ns/10ps
// counts frames since the last pointer adjustment
module tpo_guard
(
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  // frame events
  input wire logic frame_in,
  input wire logic adjust_in,
  // status
  output logic quiet_out
);
  logic [1:0] since;
  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
      since <= tpo_pkg::GUARD_FRAMES;
    else if (ce_in)
    begin
      if (adjust_in)
        since <= 2'h0;
      else if (frame_in && since != tpo_pkg::GUARD_FRAMES)
        since <= since + 2'h1;
    end
  end
  assign quiet_out = (since == tpo_pkg::GUARD_FRAMES);
endmodule : tpo_guard

/* File: rtl/tpo_pkg.sv */
// What this block does
// - with z5 select zero, software z5 value goes into every outbound spe z5 byte
// - override bit one replaces h1/h2 with arbitrary pointer; zero sends correct h1/h2; stuff and new data flag frames still send their own h1/h2
// - forced pointer never moves the real spe position
// - guard bit one allows commanded events only after 3 quiet frames
// - negative command rising: payload byte in h3, d bits inverted
// - after negative stuff pointer decreases by one and stays
// - positive command rising: stuff byte after h3, i bits inverted
// - after positive stuff pointer increases by one and stays
// - negative, positive and single flag commands clear themselves
// - continuous flag bit one repeats flag events loading the arbitrary pointer
// - single flag rising sends 1001 with arbitrary pointer, then 0110 with it
// - trace length field: 00 one byte, 01 sixteen, 10/11 sixty-four
// - j1 method 01 trace buffer, 10 software value, 11 serial input
// - arbitrary registers give flag, size and ten pointer bits on override rise
package tpo_pkg;
  localparam int ADDR_W = 16;
  localparam logic [15:0] OFS_Z5 = 16'h59b3;
  localparam logic [15:0] OFS_CTRL = 16'h59b7;
  localparam logic [15:0] OFS_J1CTL = 16'h59bb;
  localparam logic [15:0] OFS_ARB_H1 = 16'h59bf;
  localparam logic [15:0] OFS_ARB_H2 = 16'h59c3;
  localparam logic [15:0] OFS_PTR_HI = 16'h59c6;
  localparam logic [15:0] OFS_PTR_LO = 16'h59c7;
  localparam logic [15:0] OFS_J1VAL = 16'h59c8;
  localparam logic [15:0] OFS_POHCTL = 16'h5982;
  localparam int B_FORCE = 5;
  localparam int B_GUARD = 4;
  localparam int B_NEG = 3;
  localparam int B_POS = 2;
  localparam int B_CONT = 1;
  localparam int B_ONE = 0;
  localparam int B_Z5SEL = 3;
  localparam logic [7:0] CTRL_MASK = 8'h3f;
  localparam logic [7:0] J1CTL_MASK = 8'h0f;
  localparam logic [7:0] POHCTL_MASK = 8'h08;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [9:0] RST_PTR = 10'h20a;
  localparam logic [3:0] NDF_SET = 4'h9;
  localparam logic [3:0] NDF_NORM = 4'h6;
  localparam logic [1:0] SS_BITS = 2'h2;
  localparam logic [1:0] GUARD_FRAMES = 2'h3;
  localparam logic [7:0] J1_ZERO = 8'h00;
  localparam logic [6:0] LEN_1 = 7'h01;
  localparam logic [6:0] LEN_16 = 7'h10;
  localparam logic [6:0] LEN_64 = 7'h40;
  typedef enum logic [2:0] {
    TPO_EV_NONE = 3'b000,
    TPO_EV_NEG = 3'b001,
    TPO_EV_POS = 3'b010,
    TPO_EV_NDF = 3'b011,
    TPO_EV_FORCE = 3'b100
  } tpo_ev_t;
  typedef struct packed {
    logic [7:0] h1;
    logic [7:0] h2;
    logic neg_stuff;
    logic pos_stuff;
  } tpo_ptr_t;
  typedef struct packed {
    logic [7:0] j1;
    logic [7:0] z5;
    logic [6:0] trace_len;
  } tpo_poh_t;
endpackage : tpo_pkg

/* File: testbench/tpo_far_end.sv */
`timescale 1ns/10ps
// remote terminal: reads each outbound pointer and classifies it
module tpo_far_end
(
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  // outbound pointer stream
  input wire logic frame_in,
  input wire tpo_pkg::tpo_ptr_t ptr_in,
  // what the terminal saw
  output tpo_pkg::tpo_ev_t ev_out,
  output logic [9:0] ptr_val_out,
  output logic [3:0] flag_out
);
  logic frame_d;
  logic [9:0] prev;
  logic [9:0] p;
  assign p = {ptr_in.h1[1:0], ptr_in.h2};
  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      frame_d <= 1'b0;
      prev <= tpo_pkg::RST_PTR;
      ev_out <= tpo_pkg::TPO_EV_NONE;
      ptr_val_out <= 10'h000;
      flag_out <= 4'h0;
    end
    else
    begin
      frame_d <= frame_in;
      if (frame_d)
      begin
        ptr_val_out <= p;
        flag_out <= ptr_in.h1[7:4];
        if (ptr_in.h1[7:4] == tpo_pkg::NDF_SET)
        begin
          ev_out <= tpo_pkg::TPO_EV_NDF;
          prev <= p;
        end
        else if (ptr_in.neg_stuff && (p ^ prev) == 10'h155)
          ev_out <= tpo_pkg::TPO_EV_NEG;
        else if (ptr_in.pos_stuff && (p ^ prev) == 10'h2aa)
          ev_out <= tpo_pkg::TPO_EV_POS;
        else if (ptr_in.h1[7:4] != tpo_pkg::NDF_NORM)
          ev_out <= tpo_pkg::TPO_EV_FORCE;
        else
        begin
          ev_out <= tpo_pkg::TPO_EV_NONE;
          prev <= p;
        end
      end
    end
  end
endmodule : tpo_far_end

/* File: testbench/tx_path_pointer_overhead_ctrl_tb_top.sv */
`timescale 1ns/10ps
module tx_path_pointer_overhead_ctrl_tb_top;
  typedef struct packed {
    logic [15:0] a;
    logic [7:0] w;
    logic [7:0] e;
  } tpo_row_t;
  logic clk_sys_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [15:0] addr_in = 16'h0000;
  logic [7:0] wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic ce_in = 1'b1;
  logic frame_start_in = 1'b0;
  logic [7:0] trace_byte_in = 8'h3c;
  logic serial_in = 1'b1;
  logic [5:0] fcnt = 6'h00;
  logic [7:0] rdata_out;
  tpo_pkg::tpo_ptr_t ptr_out;
  tpo_pkg::tpo_poh_t poh_out;
  logic [1:0] j1_method_out;
  logic [9:0] spe_offset_out;
  tpo_pkg::tpo_ev_t ev;
  logic [9:0] pv;
  logic [3:0] fl;
  int failures = 0;
  int samples_checked = 0;
  tpo_row_t rows [9] = '{
    '{tpo_pkg::OFS_Z5, 8'ha5, 8'ha5}, '{tpo_pkg::OFS_CTRL, 8'hc0, 8'h00},
    '{tpo_pkg::OFS_J1CTL, 8'hf0, 8'h00}, '{tpo_pkg::OFS_ARB_H1, 8'ha1, 8'ha1},
    '{tpo_pkg::OFS_ARB_H2, 8'h45, 8'h45}, '{tpo_pkg::OFS_J1VAL, 8'h77, 8'h77},
    '{tpo_pkg::OFS_POHCTL, 8'hf7, 8'h00}, '{tpo_pkg::OFS_PTR_LO, 8'hff, 8'h0a},
    '{16'h1234, 8'hff, 8'h00}};
  tpo_ctrl DUT (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .ce_in(ce_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .frame_start_in(frame_start_in), .trace_byte_in(trace_byte_in),
    .path_overhead_serial_in(serial_in), .ptr_out(ptr_out), .poh_out(poh_out),
    .j1_method_out(j1_method_out), .spe_offset_out(spe_offset_out));
  tpo_far_end far (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .frame_in(frame_start_in),
    .ptr_in(ptr_out), .ev_out(ev), .ptr_val_out(pv), .flag_out(fl));
  initial
  begin
    forever #2 clk_sys_in = ~clk_sys_in;
  end
  always @(posedge clk_sys_in)
  begin
    fcnt <= (fcnt == 6'h27) ? 6'h00 : fcnt + 6'h01;
    frame_start_in <= (fcnt == 6'h27);
  end
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_sys_in);
    wr_in <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [7:0] e, input string n);
    @(posedge clk_sys_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_sys_in);
    rd_in <= 1'b0;
    #1;
    chk(n, {8'h00, e}, {8'h00, rdata_out});
  endtask : rd
  task automatic nxt();
    @(posedge clk_sys_in iff frame_start_in);
    repeat (2) @(posedge clk_sys_in);
    #1;
  endtask : nxt
  task automatic close_out();
    $display("failures %0d samples_checked %0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : close_out
  initial
  begin
    repeat (20000) @(posedge clk_sys_in);
    failures++;
    close_out();
  end
  initial
  begin
    logic [7:0] ej;
    logic [6:0] el;
    repeat (5) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    rd(tpo_pkg::OFS_CTRL, 8'h00, "ctrl reset");
    rd(tpo_pkg::OFS_PTR_HI, 8'h02, "ptr hi reset");
    rd(tpo_pkg::OFS_PTR_LO, 8'h0a, "ptr lo reset");
    nxt();
    chk("reset h1", 16'h006a, {8'h00, ptr_out.h1});
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, rows[i].e, "readback");
    end
    chk("z5", 16'h00a5, {8'h00, poh_out.z5});
    wr(tpo_pkg::OFS_POHCTL, 8'h08);
    rd(tpo_pkg::OFS_POHCTL, 8'h08, "z5 source sel");
    chk("z5 serial", 16'h00ff, {8'h00, poh_out.z5});
    wr(tpo_pkg::OFS_POHCTL, 8'h00);
    for (int k = 0; k < 4; k++)
    begin
      wr(tpo_pkg::OFS_J1CTL, {4'h0, k[1:0], k[1:0]});
      nxt();
      nxt();
      ej = (k == 0) ? 8'h00 : (k == 1) ? 8'h3c : (k == 2) ? 8'h77 : 8'hff;
      el = (k == 0) ? 7'h01 : (k == 1) ? 7'h10 : 7'h40;
      chk("trace len", {9'h000, el}, {9'h000, poh_out.trace_len});
      chk("j1 method", k[15:0], {14'h0000, j1_method_out});
      chk("j1", {8'h00, ej}, {8'h00, poh_out.j1});
    end
    wr(tpo_pkg::OFS_CTRL, 8'h08);
    rd(tpo_pkg::OFS_CTRL, 8'h00, "ctrl self clear");
    nxt();
    chk("neg ev", 16'h0001, {13'h0000, ev});
    chk("neg ptr", 16'h035f, {6'h00, pv});
    nxt();
    chk("dec ptr", 16'h0209, {6'h00, pv});
    chk("dec off", 16'h0209, {6'h00, spe_offset_out});
    wr(tpo_pkg::OFS_CTRL, 8'h14);
    nxt();
    chk("guarded ev", 16'h0000, {13'h0000, ev});
    repeat (4) nxt();
    chk("late inc", 16'h020a, {6'h00, spe_offset_out});
    wr(tpo_pkg::OFS_CTRL, 8'h04);
    nxt();
    chk("pos ev", 16'h0002, {13'h0000, ev});
    chk("pos ptr", 16'h00a0, {6'h00, pv});
    nxt();
    chk("inc ptr", 16'h020b, {6'h00, pv});
    wr(tpo_pkg::OFS_CTRL, 8'h01);
    nxt();
    chk("ndf flag", 16'h0009, {12'h000, fl});
    chk("ndf ptr", 16'h0145, {6'h00, pv});
    nxt();
    chk("norm flag", 16'h0006, {12'h000, fl});
    chk("kept ptr", 16'h0145, {6'h00, spe_offset_out});
    wr(tpo_pkg::OFS_ARB_H1, 8'h52);
    wr(tpo_pkg::OFS_ARB_H2, 8'h99);
    wr(tpo_pkg::OFS_CTRL, 8'h20);
    nxt();
    chk("force h", 16'h5299, {ptr_out.h1, ptr_out.h2});
    chk("force off", 16'h0145, {6'h00, spe_offset_out});
    chk("force ev", 16'h0004, {13'h0000, ev});
    wr(tpo_pkg::OFS_CTRL, 8'h00);
    nxt();
    chk("unforced h", 16'h6945, {ptr_out.h1, ptr_out.h2});
    wr(tpo_pkg::OFS_CTRL, 8'h02);
    nxt();
    chk("cont a", 16'h0299, {6'h00, pv});
    nxt();
    chk("cont b", 16'h0009, {12'h000, fl});
    wr(tpo_pkg::OFS_CTRL, 8'h00);
    ce_in <= 1'b0;
    wr(tpo_pkg::OFS_Z5, 8'h3c);
    ce_in <= 1'b1;
    rd(tpo_pkg::OFS_Z5, 8'ha5, "frozen z5");
    nxt();
    chk("cont off", 16'h0006, {12'h000, fl});
    @(posedge clk_sys_in);
    rstn_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    rd(tpo_pkg::OFS_PTR_LO, 8'h0a, "ptr lo second reset");
    rd(tpo_pkg::OFS_Z5, 8'h00, "z5 second reset");
    close_out();
  end
endmodule : tx_path_pointer_overhead_ctrl_tb_top
